// ==== design/sbr_cfg.svh ====
// Timing and register constants of the burst and restart controller
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define SBR_CLK_PERIOD_PS 8000
`define SBR_CYC_PER_US (1000000 / `SBR_CLK_PERIOD_PS)
`define SBR_CYC_PER_MS (1000000000 / `SBR_CLK_PERIOD_PS)

// ---------------------------------------------------------------
// Times in their own units
// ---------------------------------------------------------------
`define SBR_LEB_NS 220
`define SBR_BLANK_MS 20
`define SBR_SPIKE_US 30
`define SBR_EXT_IGNORE_MS 1
`define SBR_SOFT_START_MS 20

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SBR_ADDR_W 8
`define SBR_REG_CTRL 8'h00
`define SBR_REG_STATUS 8'h04
`define SBR_CTRL_DYN_BIT 0
`define SBR_CTRL_BURST_BIT 1
`define SBR_CTRL_RESET 2'h3

`endif

// ==== design/sbr_pkg.sv ====
// Types shared by the burst and restart controller
package sbr_pkg;

    typedef enum logic [4:0] {
        SBR_ST_OFF     = 5'h01,
        SBR_ST_SOFT    = 5'h02,
        SBR_ST_NORMAL  = 5'h04,
        SBR_ST_BURST   = 5'h08,
        SBR_ST_RESTART = 5'h10
    } sbr_state_t;

endpackage

// ==== design/sbr_sync.sv ====
// Two-stage synchroniser for a vector of comparator levels
`timescale 1ns/10ps
module sbr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    if (W < 1)
    begin : g_chk
        $error("sbr_sync: W must be at least 1");
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// ==== design/sbr_timer.sv ====
// Blanking timer: counts while run is high, clears when it drops
`timescale 1ns/10ps
module sbr_timer #(
    parameter int W = 22
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [W-1:0] limit_i,
    output logic done_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_done;

    if (W < 2)
    begin : g_chk
        $error("sbr_timer: W must be at least 2");
    end

    // Done rises after limit_i consecutive cycles of run_i
    always_comb
    begin
        next_cnt = cnt;
        next_done = done_o;
        if (!run_i)
        begin
            next_cnt = '0;
            next_done = 1'b0;
        end
        else if (!done_o)
        begin
            if (cnt == W'(limit_i - 1'b1))
                next_done = 1'b1;
            else
                next_cnt = W'(cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            done_o <= next_done;
        end
    end
endmodule

// ==== design/sbr_top.sv ====
// Burst mode, auto-restart and current-sense blanking controller
// How it works
// [RULE1] Blank current-sense results 220 ns after turn-on
// [RULE2] Steeper current slope ends pulse earlier
// [RULE3] 20 ms blanking before burst or restart
// [RULE4] Release clamp, then wait extension comparator
// [RULE5] Extra 30 us spike blanking before restart
// [RULE6] Burst fixed blanking; overload adds extension
// [RULE7] Burst counter zero, counts on low load
// [RULE8] Enter burst when 20 ms low load
// [RULE9] Burst sets flag, switches bias off
// [RULE10] Startup cell kept off in burst
// [RULE11] Feedback above 3.5 V re-enables bias
// [RULE12] Burst selects reduced 0.34 V limit
// [RULE13] Feedback down to 3.0 V stops bias
// [RULE14] Overload in burst restores full limit
// [RULE15] Fast faults enter restart immediately
// [RULE16] Overload and open loop after blanking
// [RULE17] Restart stops all gate switching
// [RULE18] Supply cycles startup cell, then soft-start
// [RULE19] Fault re-checked after startup phase
// [RULE20] Overload outside burst starts restart blanking
// [RULE21] Every restart attempt runs soft-start
// [RULE22] External request ignored first 1 ms
// [RULE23] Inputs synchronised, counters reset at power-on
`timescale 1ns/10ps
`include "sbr_cfg.svh"
module sbr_top #(
    parameter int P_BLANK_CYC = `SBR_BLANK_MS * `SBR_CYC_PER_MS,
    parameter int P_IGNORE_CYC = `SBR_EXT_IGNORE_MS * `SBR_CYC_PER_MS,
    parameter int P_SOFT_CYC = `SBR_SOFT_START_MS * `SBR_CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [`SBR_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Switch and current-sense comparators
    input wire logic switch_on_i,
    input wire logic cs_pwm_trip_i,
    input wire logic cs_limit_trip_i,
    input wire logic cs_limit_early_i,
    input wire logic cs_slope_steep_i,
    input wire logic burst_limit_comparator_i,
    // Feedback and extension comparators
    input wire logic overload_comparator_i,
    input wire logic low_load_comparator_i,
    input wire logic burst_on_comparator_i,
    input wire logic burst_off_comparator_i,
    input wire logic extension_comparator_i,
    input wire logic ext_request_i,
    // Supply and fault comparators
    input wire logic vcc_ovp_i,
    input wire logic over_temp_i,
    input wire logic vcc_uv_i,
    input wire logic vcc_on_i,
    input wire logic short_opto_i,
    // Outputs
    output logic gate_reset_o,
    output logic bias_en_o,
    output logic startup_cell_en_o,
    output logic burst_limit_gate_o,
    output logic extension_clamp_switch_o,
    output logic soft_start_o,
    output logic burst_flag_o,
    output logic restart_active_o
);
    import sbr_pkg::*;

    // ---------------------------------------------------------------
    // Timing counts
    // ---------------------------------------------------------------
    localparam int LEB_CYC =
        (`SBR_LEB_NS * 1000 + `SBR_CLK_PERIOD_PS - 1) / `SBR_CLK_PERIOD_PS;
    localparam int SPIKE_CYC = `SBR_SPIKE_US * `SBR_CYC_PER_US;
    localparam int TW = 23;

    if (P_BLANK_CYC < 2 || P_IGNORE_CYC < 2 || P_SOFT_CYC < 2 ||
        P_BLANK_CYC >= (1 << TW) || P_SOFT_CYC >= (1 << TW) ||
        P_IGNORE_CYC >= (1 << TW))
    begin : g_chk
        $error("sbr_top: timer counts out of range");
    end

    // ---------------------------------------------------------------
    // Input synchronisation
    // ---------------------------------------------------------------
    localparam int NIN = 17;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn_in;
    logic sw_on;
    logic pwm_trip;
    logic lim_trip;
    logic lim_early;
    logic steep;
    logic burst_lim;
    logic fb_over;
    logic fb_low;
    logic fb_on;
    logic fb_off;
    logic ext_chg;
    logic ext_req;
    logic ovp;
    logic otp;
    logic uv;
    logic von;
    logic opto;

    assign raw_in = {switch_on_i, cs_pwm_trip_i, cs_limit_trip_i, cs_limit_early_i,
                     cs_slope_steep_i, burst_limit_comparator_i, overload_comparator_i,
                     low_load_comparator_i, burst_on_comparator_i, burst_off_comparator_i,
                     extension_comparator_i, ext_request_i, vcc_ovp_i, over_temp_i,
                     vcc_uv_i, vcc_on_i, short_opto_i};

    sbr_sync #(.W(NIN)) u_sync ( // [RULE23]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(raw_in),
        .q_o(syn_in)
    );

    assign {sw_on, pwm_trip, lim_trip, lim_early, steep, burst_lim, fb_over, fb_low,
            fb_on, fb_off, ext_chg, ext_req, ovp, otp, uv, von, opto} = syn_in;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [31:0] next_rdata;
    sbr_state_t state;
    sbr_state_t next_state;
    logic bias_on;
    logic next_bias_on;
    logic cell_req;
    logic next_cell_req;

    always_comb
    begin
        next_ctrl = ctrl;
        next_rdata = 32'h0000_0000;
        if (reg_wr_i && reg_addr_i == `SBR_REG_CTRL)
            next_ctrl = reg_wdata_i[1:0];
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `SBR_REG_CTRL: next_rdata = {30'h0, ctrl};
                `SBR_REG_STATUS: next_rdata = {22'h0, extension_clamp_switch_o,
                    burst_limit_gate_o, startup_cell_en_o, bias_en_o, gate_reset_o,
                    state};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= `SBR_CTRL_RESET;
            reg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            reg_rdata_o <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Blanking timers
    // ---------------------------------------------------------------
    logic in_run;
    logic leb_done;
    logic burst_blank_done;
    logic ovl_blank_done;
    logic restart_gate;
    logic spike_done;
    logic ignore_done;
    logic soft_done;

    // States in which the controller is awake and may switch
    assign in_run = (state == SBR_ST_SOFT) || (state == SBR_ST_NORMAL) ||
                    (state == SBR_ST_BURST);

    sbr_timer #(.W(TW)) u_leb ( // [RULE1]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(sw_on),
        .limit_i(TW'(LEB_CYC)),
        .done_o(leb_done)
    );

    // Counter stays cleared in normal operation until feedback is low
    sbr_timer #(.W(TW)) u_burst_blank ( // [RULE7] [RULE3] [RULE6]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state == SBR_ST_NORMAL && fb_low && ctrl[`SBR_CTRL_BURST_BIT]),
        .limit_i(TW'(P_BLANK_CYC)),
        .done_o(burst_blank_done)
    );

    sbr_timer #(.W(TW)) u_ovl_blank ( // [RULE20] [RULE3]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state == SBR_ST_NORMAL && fb_over),
        .limit_i(TW'(P_BLANK_CYC)),
        .done_o(ovl_blank_done)
    );

    // Extension node must climb to its upper level once unclamped
    assign restart_gate = ovl_blank_done && ext_chg; // [RULE4] [RULE6]

    sbr_timer #(.W(TW)) u_spike ( // [RULE5]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(restart_gate),
        .limit_i(TW'(SPIKE_CYC)),
        .done_o(spike_done)
    );

    // Counts from the start of each power-on, so a request is blanked
    sbr_timer #(.W(TW)) u_ignore ( // [RULE22]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(in_run),
        .limit_i(TW'(P_IGNORE_CYC)),
        .done_o(ignore_done)
    );

    sbr_timer #(.W(TW)) u_soft ( // [RULE21]
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state == SBR_ST_SOFT),
        .limit_i(TW'(P_SOFT_CYC)),
        .done_o(soft_done)
    );

    // ---------------------------------------------------------------
    // Mode control
    // ---------------------------------------------------------------
    logic fast_fault;
    logic slow_fault;

    assign fast_fault = ovp || otp || uv || opto || (ext_req && ignore_done); // [RULE15]
    assign slow_fault = fb_over; // [RULE16]

    always_comb
    begin
        next_state = state;
        next_bias_on = bias_on;
        next_cell_req = cell_req;
        case (state)
            SBR_ST_OFF:
            begin
                next_cell_req = 1'b1;
                if (von)
                begin
                    next_cell_req = 1'b0;
                    next_state = SBR_ST_SOFT;
                end
            end
            SBR_ST_SOFT:
            begin
                if (fast_fault)
                    next_state = SBR_ST_RESTART;
                else if (soft_done)
                    // A fault still present after start-up goes back to restart
                    next_state = slow_fault ? SBR_ST_RESTART : SBR_ST_NORMAL; // [RULE19]
            end
            SBR_ST_NORMAL:
            begin
                if (fast_fault || spike_done) // [RULE16] [RULE5]
                    next_state = SBR_ST_RESTART;
                else if (burst_blank_done && fb_low) // [RULE8]
                begin
                    next_state = SBR_ST_BURST;
                    next_bias_on = 1'b0; // [RULE9]
                end
            end
            SBR_ST_BURST:
            begin
                if (fast_fault)
                    next_state = SBR_ST_RESTART;
                else if (fb_over)
                begin
                    next_state = SBR_ST_NORMAL; // [RULE14]
                    next_bias_on = 1'b1;
                end
                else if (fb_on)
                    next_bias_on = 1'b1; // [RULE11]
                else if (fb_off)
                    next_bias_on = 1'b0; // [RULE13]
            end
            SBR_ST_RESTART:
            begin
                // Supply collapses, the cell recharges it, then soft-start again
                if (uv)
                    next_cell_req = 1'b1; // [RULE18]
                if (cell_req && von)
                begin
                    next_cell_req = 1'b0;
                    next_state = SBR_ST_SOFT; // [RULE18] [RULE21]
                end
            end
            default:
            begin
                next_state = SBR_ST_OFF;
                next_cell_req = 1'b1;
            end
        endcase
        if (next_state != SBR_ST_BURST)
            next_bias_on = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= SBR_ST_OFF; // [RULE23]
            bias_on <= 1'b1;
            cell_req <= 1'b1;
        end
        else
        begin
            state <= next_state;
            bias_on <= next_bias_on;
            cell_req <= next_cell_req;
        end
    end

    // ---------------------------------------------------------------
    // Pulse termination and outputs
    // ---------------------------------------------------------------
    logic blank;
    logic dyn_trip;
    logic cur_trip;
    logic sw_allowed;
    logic next_gate_reset;
    logic next_bias_en;
    logic next_cell_en;
    logic next_limit_gate;
    logic next_clamp;

    assign blank = !leb_done; // [RULE1]

    // Early threshold only counts when the slope is steep: the switch-off
    // delay then adds more overshoot, so the pulse must end sooner
    assign dyn_trip = lim_trip ||
        (ctrl[`SBR_CTRL_DYN_BIT] && steep && lim_early); // [RULE2]

    assign cur_trip = (next_state == SBR_ST_BURST) ? burst_lim : dyn_trip; // [RULE12]

    // Burst keeps switching only while its bias burst is on
    assign sw_allowed = in_run && !(state == SBR_ST_BURST && !bias_on);

    always_comb
    begin
        next_gate_reset = 1'b1; // [RULE17]
        if (next_state != SBR_ST_RESTART && next_state != SBR_ST_OFF && sw_allowed)
            next_gate_reset = !blank && (pwm_trip || cur_trip);
        next_bias_en = (next_state == SBR_ST_SOFT) || (next_state == SBR_ST_NORMAL) ||
                       (next_state == SBR_ST_BURST && next_bias_on); // [RULE9] [RULE11]
        next_cell_en = next_cell_req && next_state != SBR_ST_BURST; // [RULE10]
        next_limit_gate = next_state == SBR_ST_BURST; // [RULE12] [RULE14]
        next_clamp = !(next_state == SBR_ST_NORMAL && ovl_blank_done); // [RULE4]
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gate_reset_o <= 1'b1;
            bias_en_o <= 1'b0;
            startup_cell_en_o <= 1'b1;
            burst_limit_gate_o <= 1'b0;
            extension_clamp_switch_o <= 1'b1;
            soft_start_o <= 1'b0;
            burst_flag_o <= 1'b0;
            restart_active_o <= 1'b0;
        end
        else
        begin
            gate_reset_o <= next_gate_reset;
            bias_en_o <= next_bias_en;
            startup_cell_en_o <= next_cell_en;
            burst_limit_gate_o <= next_limit_gate;
            extension_clamp_switch_o <= next_clamp;
            soft_start_o <= next_state == SBR_ST_SOFT;
            burst_flag_o <= next_state == SBR_ST_BURST; // [RULE9]
            restart_active_o <= next_state == SBR_ST_RESTART;
        end
    end
endmodule

// ==== bench/sbr_top_sva_sva.sv ====
// Port checker for the burst and restart controller
`timescale 1ns/10ps
module sbr_top_sva #(
    parameter int P_BLANK_CYC = 50
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic switch_on_i,
    input wire logic overload_comparator_i,
    input wire logic low_load_comparator_i,
    input wire logic burst_on_comparator_i,
    input wire logic burst_off_comparator_i,
    input wire logic extension_comparator_i,
    input wire logic ext_request_i,
    input wire logic vcc_ovp_i,
    input wire logic over_temp_i,
    input wire logic vcc_uv_i,
    input wire logic short_opto_i,
    input wire logic gate_reset_o,
    input wire logic bias_en_o,
    input wire logic startup_cell_en_o,
    input wire logic burst_limit_gate_o,
    input wire logic extension_clamp_switch_o,
    input wire logic soft_start_o,
    input wire logic burst_flag_o,
    input wire logic restart_active_o
);
    // Two synchroniser stages pass before any count can start
    localparam logic [15:0] BLANK_MIN = 16'(P_BLANK_CYC + 2);
    localparam logic [15:0] SPIKE_MIN = 16'h0ea8;
    logic [15:0] ll_cnt, next_ll_cnt, ov_cnt, next_ov_cnt;
    logic [15:0] ex_cnt, next_ex_cnt, sw_cnt, next_sw_cnt;
    logic fast_fault;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------
    // Run lengths of raw input levels
    // ------
    assign fast_fault = vcc_ovp_i | over_temp_i | vcc_uv_i | short_opto_i | ext_request_i;
    always_comb
    begin
        next_ll_cnt = low_load_comparator_i ? ll_cnt + 16'h1 : 16'h0;
        next_ov_cnt = overload_comparator_i ? ov_cnt + 16'h1 : 16'h0;
        next_ex_cnt = extension_comparator_i ? ex_cnt + 16'h1 : 16'h0;
        next_sw_cnt = switch_on_i ? sw_cnt + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {ll_cnt, ov_cnt, ex_cnt, sw_cnt} <= 64'h0;
        else
            {ll_cnt, ov_cnt, ex_cnt, sw_cnt} <= {next_ll_cnt, next_ov_cnt, next_ex_cnt, next_sw_cnt};
    end

    // ------
    // Properties
    // ------
    property p_leb;
        (sw_cnt >= 16'h4 && sw_cnt <= 16'h1a && !gate_reset_o) |=>
            (!gate_reset_o || restart_active_o || burst_flag_o);
    endproperty
    a_leb: assert property (p_leb) else $error("gate reset inside blanking");
    property p_burst_entry;
        $rose(burst_flag_o) |-> ll_cnt >= BLANK_MIN && !bias_en_o;
    endproperty
    a_burst_entry: assert property (p_burst_entry) else $error("burst entry wrong");
    property p_burst_limit;
        burst_flag_o |-> burst_limit_gate_o && !startup_cell_en_o;
    endproperty
    a_burst_limit: assert property (p_burst_limit) else $error("burst limit or cell");
    property p_bias_on;
        (burst_flag_o && burst_on_comparator_i && !overload_comparator_i) [*6] |-> bias_en_o;
    endproperty
    a_bias_on: assert property (p_bias_on) else $error("bias not resumed");
    property p_bias_off;
        (burst_flag_o && burst_off_comparator_i && !burst_on_comparator_i) [*6] |-> !bias_en_o;
    endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias not stopped");
    property p_burst_exit;
        (burst_flag_o && overload_comparator_i) |-> ##[1:6] (!burst_flag_o && !burst_limit_gate_o);
    endproperty
    a_burst_exit: assert property (p_burst_exit) else $error("burst not left");
    property p_fast;
        ($rose(vcc_ovp_i | over_temp_i | vcc_uv_i | short_opto_i) && !gate_reset_o) |->
            ##[1:6] restart_active_o;
    endproperty
    a_fast: assert property (p_fast) else $error("fast fault not taken");
    property p_clamp;
        $fell(extension_clamp_switch_o) |-> ov_cnt >= BLANK_MIN;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp released early");
    property p_spike;
        ($rose(restart_active_o) && !$past(extension_clamp_switch_o) && !fast_fault &&
            !$past(soft_start_o)) |-> ex_cnt >= SPIKE_MIN;
    endproperty
    a_spike: assert property (p_spike) else $error("restart before spike wait");
    property p_stop;
        restart_active_o |-> gate_reset_o;
    endproperty
    a_stop: assert property (p_stop) else $error("switching in restart");
endmodule

bind sbr_top sbr_top_sva #(.P_BLANK_CYC(P_BLANK_CYC)) sbr_top_sva_i (.*);

// ==== bench/testbench.sv ====
// Self-checking bench for the burst and restart controller
`timescale 1ns/10ps
module testbench;
    import sbr_pkg::*;
    localparam int P_BLANK = 50;
    // Trip inputs {burst limit, pwm, limit, steep, early} and the expected gate reset
    localparam logic [5:0] TRIPS [5] = '{6'h11, 6'h09, 6'h07, 6'h04, 6'h20};
    logic clk_i, rst_n_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rdata;
    logic switch_on_i, cs_pwm_trip_i, cs_limit_trip_i, cs_limit_early_i, cs_slope_steep_i;
    logic burst_limit_comparator_i, overload_comparator_i, low_load_comparator_i;
    logic burst_on_comparator_i, burst_off_comparator_i, extension_comparator_i, ext_request_i;
    logic vcc_ovp_i, over_temp_i, vcc_uv_i, vcc_on_i, short_opto_i;
    logic gate_reset_o, bias_en_o, startup_cell_en_o, burst_limit_gate_o;
    logic extension_clamp_switch_o, soft_start_o, burst_flag_o, restart_active_o;
    int error_cnt, comparisons;

    sbr_top #(.P_BLANK_CYC(P_BLANK), .P_IGNORE_CYC(20), .P_SOFT_CYC(40)) sbr_top_i (.*);

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ------
    // Access and compare tasks
    // ------
    task automatic run(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic check);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rdata = reg_rdata_o;
        if (check)
            chk($sformatf("reg %h", a), exp, rdata);
    endtask
    // Polls the state through the status register, giving up after 3000 reads
    task automatic wait_st(input sbr_state_t st);
        int n;
        n = 0;
        rdata = 32'h0;
        while (rdata[4:0] !== st && n < 3000)
        begin
            rd(8'h04, 32'h0, 1'b0);
            n++;
        end
        chk("state", {27'h0, st}, {27'h0, rdata[4:0]});
    endtask
    task automatic power_up;
        vcc_on_i <= 1'b0;
        vcc_uv_i <= 1'b1;
        run(6);
        chk("cell_on", 32'h1, startup_cell_en_o);
        vcc_uv_i <= 1'b0;
        vcc_on_i <= 1'b1;
        wait_st(SBR_ST_SOFT);
        chk("cell_off", 32'h0, startup_cell_en_o);
        chk("soft", 32'h1, soft_start_o);
    endtask
    task automatic trip(input logic [4:0] t, input logic e);
        @(posedge clk_i);
        {burst_limit_comparator_i, cs_pwm_trip_i, cs_limit_trip_i, cs_slope_steep_i,
            cs_limit_early_i} <= t;
        switch_on_i <= 1'b1;
        run(16);
        chk("gate_blank", 32'h0, gate_reset_o);
        run(24);
        chk("gate_trip", {31'h0, e}, gate_reset_o);
        {burst_limit_comparator_i, cs_pwm_trip_i, cs_limit_trip_i, cs_slope_steep_i,
            cs_limit_early_i} <= 5'h0;
        switch_on_i <= 1'b0;
        run(4);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------
    // Tests
    // ------
    initial
    begin
        error_cnt = 0;
        comparisons = 0;
        rst_n_i = 1'b0;
        {reg_wr_i, reg_rd_i, switch_on_i, cs_pwm_trip_i, cs_limit_trip_i, cs_limit_early_i,
            cs_slope_steep_i, burst_limit_comparator_i, overload_comparator_i,
            low_load_comparator_i, burst_on_comparator_i, burst_off_comparator_i,
            extension_comparator_i, ext_request_i, vcc_ovp_i, over_temp_i, vcc_uv_i,
            vcc_on_i, short_opto_i} = 19'h0;
        reg_addr_i = 8'h0;
        reg_wdata_i = 32'h0;
        run(8);
        chk("reset_outs", 32'ha8, {gate_reset_o, bias_en_o, startup_cell_en_o, burst_limit_gate_o,
            extension_clamp_switch_o, soft_start_o, burst_flag_o, restart_active_o});
        rst_n_i <= 1'b1;
        rd(8'h04, 32'h2a1, 1'b1);
        rd(8'h00, 32'h3, 1'b1);
        wr(8'h08, 32'hffffffff);
        rd(8'h08, 32'h0, 1'b1);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h2a1, 1'b1);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h1, 1'b1);
        wr(8'h00, 32'h3);
        $display("test registers done");
        power_up();
        ext_request_i <= 1'b1;
        run(8);
        chk("ext_ignored", 32'h0, restart_active_o);
        wait_st(SBR_ST_RESTART);
        chk("gate_stop", 32'h1, gate_reset_o);
        ext_request_i <= 1'b0;
        power_up();
        wait_st(SBR_ST_NORMAL);
        $display("test startup done");
        for (int k = 0; k < 5; k++)
            trip(TRIPS[k][5:1], TRIPS[k][0]);
        wr(8'h00, 32'h2);
        trip(5'h03, 1'b0);
        wr(8'h00, 32'h3);
        $display("test blanking done");
        low_load_comparator_i <= 1'b1;
        run(30);
        low_load_comparator_i <= 1'b0;
        run(2);
        low_load_comparator_i <= 1'b1;
        run(P_BLANK - 8);
        chk("burst_early", 32'h0, burst_flag_o);
        wait_st(SBR_ST_BURST);
        chk("burst_outs", 32'h3, {bias_en_o, startup_cell_en_o, burst_limit_gate_o,
            burst_flag_o});
        low_load_comparator_i <= 1'b0;
        burst_on_comparator_i <= 1'b1;
        run(8);
        chk("bias_on", 32'h1, bias_en_o);
        trip(5'h10, 1'b1);
        trip(5'h04, 1'b0);
        burst_on_comparator_i <= 1'b0;
        burst_off_comparator_i <= 1'b1;
        run(8);
        chk("bias_off", 32'h0, bias_en_o);
        burst_off_comparator_i <= 1'b0;
        overload_comparator_i <= 1'b1;
        wait_st(SBR_ST_NORMAL);
        chk("full_limit", 32'h0, burst_limit_gate_o);
        $display("test burst done");
        run(30);
        chk("clamp_held", 32'h1, extension_clamp_switch_o);
        run(35);
        chk("clamp_free", 32'h0, extension_clamp_switch_o);
        run(4000);
        chk("no_restart", 32'h0, restart_active_o);
        extension_comparator_i <= 1'b1;
        run(3700);
        chk("spike_wait", 32'h0, restart_active_o);
        wait_st(SBR_ST_RESTART);
        chk("gate_stop", 32'h1, gate_reset_o);
        extension_comparator_i <= 1'b0;
        power_up();
        wait_st(SBR_ST_RESTART);
        overload_comparator_i <= 1'b0;
        power_up();
        wait_st(SBR_ST_NORMAL);
        $display("test overload done");
        for (int k = 0; k < 4; k++)
        begin
            {vcc_ovp_i, over_temp_i, vcc_uv_i, short_opto_i} <= 4'h8 >> k;
            run(6);
            chk("fast_fault", 32'h1, restart_active_o);
            {vcc_ovp_i, over_temp_i, vcc_uv_i, short_opto_i} <= 4'h0;
            power_up();
            wait_st(SBR_ST_NORMAL);
        end
        $display("test faults done");
        close_out();
    end

    // Run takes about 8800 cycles
    initial
    begin
        run(40000);
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        close_out();
    end
endmodule
